// [shared/svm_params.svh]
`ifndef SVM_PARAMS_SVH
`define SVM_PARAMS_SVH

// Page table entry flag positions
`define SVM_PTE_V         0
`define SVM_PTE_R         1
`define SVM_PTE_W         2
`define SVM_PTE_X         3
`define SVM_PTE_U         4
`define SVM_PTE_G         5
`define SVM_PTE_A         6
`define SVM_PTE_D         7
`define SVM_PTE_PPN_LSB   10
`define SVM_PTE_PPN_MSB   53

// Translation control register fields
`define SVM_CTL_PPN_MSB   43
`define SVM_CTL_TAG_LSB   44
`define SVM_CTL_TAG_MSB   59
`define SVM_CTL_MODE_LSB  60
`define SVM_CTL_MODE_MSB  63
`define SVM_CTL_RESET     64'h0000_0000_0000_0000
`define SVM_MODE_BARE     4'h0
`define SVM_MODE_PAGED39  4'h8
`define SVM_MODE_PAGED48  4'h9

// Address geometry
`define SVM_PAGE_SHIFT    12
`define SVM_VA_TOP        38
`define SVM_VPN_W         27

// Host register byte offsets
`define SVM_REG_CMD       8'h00
`define SVM_REG_ACC       8'h04
`define SVM_REG_VA_LO     8'h08
`define SVM_REG_VA_HI     8'h0C
`define SVM_REG_PTE_LO    8'h10
`define SVM_REG_PTE_HI    8'h14
`define SVM_REG_CTL_LO    8'h18
`define SVM_REG_CTL_HI    8'h1C
`define SVM_REG_SPACE     8'h20
`define SVM_REG_STATUS    8'h24
`define SVM_REG_PA_LO     8'h28
`define SVM_REG_PA_HI     8'h2C

// Command and field bits of host registers
`define SVM_CMD_ACCESS    0
`define SVM_CMD_FENCE     1
`define SVM_CMD_CTL_WR    2
`define SVM_ACC_USER      2
`define SVM_ACC_SUM       3
`define SVM_ACC_ADDR_NZ   4
`define SVM_ACC_SPACE_NZ  5
`define SVM_ACC_RESET     32'h0000_0000

`endif

// [shared/svm_pkg.sv]
package svm_pkg;
  typedef enum logic [1:0] {
    SVM_FETCH,
    SVM_LOAD,
    SVM_STORE
  } svm_kind_t;

  typedef enum logic [2:0] {
    SVM_IDLE,
    SVM_ACC_REQ,
    SVM_ACC_WAIT,
    SVM_FEN_REQ,
    SVM_FEN_WAIT
  } svm_state_t;
endpackage : svm_pkg

// [shared/svm_if.sv]
`timescale 1ns/1ns
interface svm_if;
  import svm_pkg::*;
  logic             req_valid;
  logic             req_ready;
  svm_kind_t        req_kind;
  logic             req_user;
  logic             req_sum;
  logic [63:0]      req_vaddr;
  logic [63:0]      req_pte;
  logic             resp_valid;
  logic             resp_fault;
  svm_kind_t        resp_cause;
  logic             resp_hit;
  logic [63:0]      resp_paddr;
  logic             fence_valid;
  logic             fence_ready;
  logic             fence_addr_nz;
  logic             fence_space_nz;
  logic [63:0]      fence_addr;
  logic [63:0]      fence_space;
  logic             fence_done;
  logic             ctl_we;
  logic [63:0]      ctl_wdata;
  logic [63:0]      ctl_rdata;

  modport dev (
    input  req_valid, req_kind, req_user, req_sum, req_vaddr, req_pte,
    output req_ready, resp_valid, resp_fault, resp_cause, resp_hit, resp_paddr,
    input  fence_valid, fence_addr_nz, fence_space_nz, fence_addr, fence_space,
    output fence_ready, fence_done,
    input  ctl_we, ctl_wdata,
    output ctl_rdata
  );

  modport core (
    output req_valid, req_kind, req_user, req_sum, req_vaddr, req_pte,
    input  req_ready, resp_valid, resp_fault, resp_cause, resp_hit, resp_paddr,
    output fence_valid, fence_addr_nz, fence_space_nz, fence_addr, fence_space,
    input  fence_ready, fence_done,
    output ctl_we, ctl_wdata,
    input  ctl_rdata
  );
endinterface : svm_if

// [core/svm_perm_chk.sv]
`timescale 1ns/1ns
`include "svm_params.svh"
module svm_perm_chk (
  input  wire logic [7:0]         pte_flags_in,
  input  wire svm_pkg::svm_kind_t kind_in,
  input  wire logic               user_in,
  input  wire logic               sum_in,
  output logic                    fault_out
);
  import svm_pkg::*;

  logic v, r, w, x, u, a, d;
  assign v = pte_flags_in[`SVM_PTE_V];
  assign r = pte_flags_in[`SVM_PTE_R];
  assign w = pte_flags_in[`SVM_PTE_W];
  assign x = pte_flags_in[`SVM_PTE_X];
  assign u = pte_flags_in[`SVM_PTE_U];
  assign a = pte_flags_in[`SVM_PTE_A];
  assign d = pte_flags_in[`SVM_PTE_D];

  // Fault decode; invalid entry short-circuits so other bits never matter
  always_comb begin
    fault_out = 1'b0;
    if (!v) begin
      fault_out = 1'b1;
    end else if (w && !r) begin
      fault_out = 1'b1;
    end else if (!r && !w && !x) begin
      fault_out = 1'b1;
    end else begin
      case (kind_in)
        SVM_FETCH: fault_out = !x;
        SVM_LOAD:  fault_out = !r;
        SVM_STORE: fault_out = !w;
        default:   fault_out = 1'b1;
      endcase
      if (user_in && !u) begin
        fault_out = 1'b1;
      end
      if (!user_in && u && (kind_in == SVM_FETCH)) begin
        fault_out = 1'b1;
      end
      if (!user_in && u && (kind_in != SVM_FETCH) && !sum_in) begin
        fault_out = 1'b1;
      end
      // No hardware update of A/D: fault instead
      if (!a || ((kind_in == SVM_STORE) && !d)) begin
        fault_out = 1'b1;
      end
    end
  end
endmodule : svm_perm_chk

// [core/svm_mmu_dev.sv]
`timescale 1ns/1ns
`include "svm_params.svh"
// Overview of operation
// - Invalid entry: ignore all other bits
// - XWR all clear means pointer, else leaf
// - Writable-but-unreadable entry is never valid mapping
// - Fetch without execute gives fetch fault
// - Load without read gives load fault
// - Store or atomic without write: store fault
// - Supervisor data on user page needs SUM
// - Supervisor never fetches from user page
// - No A/D update; fault on clear A, or on clear D for store
// - Software keeps D/A/U clear in pointers
// - 64-bit read/write translation control register
// - Root page number is address over 4 KiB
// - Mode zero: bare, other fields ignored
// - Mode eight is only paged scheme
// - Control write gives no ordering; fence after
// - Fence orders stores and flushes TLB entries
// - Fence acts on this hart only
// - Both operands zero: flush everything
// - Space only: flush that space, keep global
// - Address only: flush that page, all spaces
// - Both: flush page in space, keep global
// - Ignore space bits above implemented width
module svm_mmu_dev #(
  parameter int TLB_ENTRIES = 4,
  parameter int TAG_W       = 16
) (
  input  wire logic          clk_sys_in,
  input  wire logic          reset_in,
  svm_if.dev                 link,
  output logic [63:0]        ctl_out,
  output logic [TLB_ENTRIES-1:0] tlb_valid_out
);
  import svm_pkg::*;

  localparam int IDX_W = (TLB_ENTRIES > 1) ? $clog2(TLB_ENTRIES) : 1;
  localparam int VPN_W = `SVM_VPN_W;

  logic [63:0]            ctl_q;
  logic [TLB_ENTRIES-1:0] ent_valid_q;
  logic [VPN_W-1:0]       ent_vpn_q   [TLB_ENTRIES];
  logic [TAG_W-1:0]       ent_tag_q   [TLB_ENTRIES];
  logic [63:0]            ent_pte_q   [TLB_ENTRIES];
  logic [IDX_W-1:0]       fill_ptr_q;
  logic                   resp_valid_q;
  logic                   resp_fault_q;
  svm_kind_t              resp_cause_q;
  logic                   resp_hit_q;
  logic [63:0]            resp_paddr_q;
  logic                   fence_done_q;

  logic [3:0]             cur_mode;
  logic [TAG_W-1:0]       cur_tag;
  logic [TAG_W-1:0]       fence_tag;
  logic [VPN_W-1:0]       req_vpn;
  logic [VPN_W-1:0]       fence_vpn;
  logic                   bare;
  logic                   canon_ok;
  logic [TLB_ENTRIES-1:0] hit_vec;
  logic [TLB_ENTRIES-1:0] flush_vec;
  logic                   hit;
  logic [63:0]            hit_pte;
  logic [63:0]            use_pte;
  logic                   perm_fault;
  logic                   req_take;
  logic                   fence_take;
  logic [3:0]             wr_mode;

  // Entry match on page number and tag; lookups skip the tag of global entries, tag-checked fences never match them
  function automatic logic ent_match(input logic [VPN_W-1:0] ent_vpn,
                                     input logic [VPN_W-1:0] vpn,
                                     input logic             chk_vpn,
                                     input logic [TAG_W-1:0] ent_tag,
                                     input logic [TAG_W-1:0] tag,
                                     input logic             chk_tag,
                                     input logic             is_glb);
    logic vpn_ok;
    logic tag_ok;
    vpn_ok = !chk_vpn || (ent_vpn == vpn);
    tag_ok = !chk_tag || (!is_glb && (ent_tag == tag));
    return vpn_ok && tag_ok;
  endfunction : ent_match

  // Field views; only the implemented tag width is ever compared
  assign cur_mode  = ctl_q[`SVM_CTL_MODE_MSB:`SVM_CTL_MODE_LSB];
  assign cur_tag   = ctl_q[`SVM_CTL_TAG_LSB +: TAG_W];
  assign fence_tag = link.fence_space[TAG_W-1:0];
  assign req_vpn   = link.req_vaddr[`SVM_PAGE_SHIFT +: VPN_W];
  assign fence_vpn = link.fence_addr[`SVM_PAGE_SHIFT +: VPN_W];
  assign bare      = (cur_mode == `SVM_MODE_BARE);
  assign canon_ok  = (link.req_vaddr[63:`SVM_VA_TOP] == {26{link.req_vaddr[`SVM_VA_TOP]}})
                  || (link.req_vaddr[63:`SVM_VA_TOP] == 26'h000_0000);
  assign wr_mode   = link.ctl_wdata[`SVM_CTL_MODE_MSB:`SVM_CTL_MODE_LSB];

  // Fence has priority; accesses wait so the flush is seen first
  assign fence_take       = link.fence_valid;
  assign link.fence_ready = 1'b1;
  assign link.req_ready   = !link.fence_valid;
  assign req_take         = link.req_valid && link.req_ready;

  // Per-entry lookup and fence selection
  genvar gi;
  generate
    for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_ent
      assign hit_vec[gi] = ent_valid_q[gi]
                        && ent_match(ent_vpn_q[gi], req_vpn, 1'b1, ent_tag_q[gi], cur_tag,
                                     !ent_pte_q[gi][`SVM_PTE_G], 1'b0);
      assign flush_vec[gi] = ent_match(ent_vpn_q[gi], fence_vpn, link.fence_addr_nz,
                                       ent_tag_q[gi], fence_tag, link.fence_space_nz,
                                       ent_pte_q[gi][`SVM_PTE_G]);
    end
  endgenerate

  // First hitting entry supplies the cached leaf
  always_comb begin
    hit     = 1'b0;
    hit_pte = 64'h0000_0000_0000_0000;
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      if (hit_vec[i] && !hit) begin
        hit     = 1'b1;
        hit_pte = ent_pte_q[i];
      end
    end
  end

  assign use_pte = hit ? hit_pte : link.req_pte;

  svm_perm_chk u_chk (
    .pte_flags_in (use_pte[7:0]),
    .kind_in      (link.req_kind),
    .user_in      (link.req_user),
    .sum_in       (link.req_sum),
    .fault_out    (perm_fault)
  );

  // Translation control; unsupported modes leave it unchanged
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctl_q <= `SVM_CTL_RESET;
    end else if (link.ctl_we) begin
      if ((wr_mode == `SVM_MODE_BARE) || (wr_mode == `SVM_MODE_PAGED39)) begin
        ctl_q <= link.ctl_wdata;
      end
    end
  end

  // TLB contents; a control write flushes nothing by design
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ent_valid_q <= '0;
      fill_ptr_q  <= '0;
    end else if (fence_take) begin
      ent_valid_q <= ent_valid_q & ~flush_vec;
    end else if (req_take && !bare && canon_ok && !hit && !perm_fault) begin
      ent_valid_q[fill_ptr_q] <= 1'b1;
      fill_ptr_q <= (fill_ptr_q == IDX_W'(TLB_ENTRIES - 1)) ? '0 : fill_ptr_q + 1'b1;
    end
  end

  // Entry payload needs no reset; guarded by the valid bits
  always_ff @(posedge clk_sys_in) begin
    if (req_take && !fence_take && !bare && canon_ok && !hit && !perm_fault) begin
      ent_vpn_q[fill_ptr_q] <= req_vpn;
      ent_tag_q[fill_ptr_q] <= cur_tag;
      ent_pte_q[fill_ptr_q] <= link.req_pte;
    end
  end

  // Access answer, one cycle after the request is taken
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      resp_valid_q <= 1'b0;
      resp_fault_q <= 1'b0;
      resp_cause_q <= SVM_FETCH;
      resp_hit_q   <= 1'b0;
      resp_paddr_q <= 64'h0000_0000_0000_0000;
    end else begin
      resp_valid_q <= req_take;
      if (req_take) begin
        resp_cause_q <= link.req_kind;
        if (bare) begin
          resp_fault_q <= 1'b0;
          resp_hit_q   <= 1'b0;
          resp_paddr_q <= link.req_vaddr;
        end else begin
          resp_fault_q <= !canon_ok || perm_fault;
          resp_hit_q   <= hit;
          resp_paddr_q <= {8'h00, use_pte[`SVM_PTE_PPN_MSB:`SVM_PTE_PPN_LSB],
                           link.req_vaddr[`SVM_PAGE_SHIFT-1:0]};
        end
      end
    end
  end

  // Fence completion pulse; local hart only
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fence_done_q <= 1'b0;
    end else begin
      fence_done_q <= fence_take;
    end
  end

  assign link.resp_valid = resp_valid_q;
  assign link.resp_fault = resp_fault_q;
  assign link.resp_cause = resp_cause_q;
  assign link.resp_hit   = resp_hit_q;
  assign link.resp_paddr = resp_paddr_q;
  assign link.fence_done = fence_done_q;
  assign link.ctl_rdata  = ctl_q;
  assign ctl_out         = ctl_q;
  assign tlb_valid_out   = ent_valid_q;
endmodule : svm_mmu_dev

// [core/svm_core_end.sv]
`timescale 1ns/1ns
`include "svm_params.svh"
module svm_core_end (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  svm_if.core              link
);
  import svm_pkg::*;

  svm_state_t  state_q;
  logic [31:0] acc_q;
  logic [63:0] va_q;
  logic [63:0] pte_q;
  logic [63:0] ctl_q;
  logic [31:0] space_q;
  logic [63:0] pa_q;
  logic        done_q;
  logic        fault_q;
  svm_kind_t   cause_q;
  logic        hit_q;
  logic        ctl_we_q;
  logic        wr_en;
  logic        mapped;
  logic        cmd_wr;

  assign wr_en  = psel_in && penable_in && pwrite_in;
  assign cmd_wr = wr_en && (paddr_in == `SVM_REG_CMD);
  assign mapped = (paddr_in <= `SVM_REG_PA_HI) && (paddr_in[1:0] == 2'b00);

  // Zero-wait slave; unmapped or misaligned offsets answer with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  // Staging registers written by software
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      acc_q   <= `SVM_ACC_RESET;
      va_q    <= 64'h0000_0000_0000_0000;
      pte_q   <= 64'h0000_0000_0000_0000;
      ctl_q   <= `SVM_CTL_RESET;
      space_q <= 32'h0000_0000;
    end else if (wr_en) begin
      case (paddr_in)
        `SVM_REG_ACC:    acc_q         <= pwdata_in;
        `SVM_REG_VA_LO:  va_q[31:0]    <= pwdata_in;
        `SVM_REG_VA_HI:  va_q[63:32]   <= pwdata_in;
        `SVM_REG_PTE_LO: pte_q[31:0]   <= pwdata_in;
        `SVM_REG_PTE_HI: pte_q[63:32]  <= pwdata_in;
        `SVM_REG_CTL_LO: ctl_q[31:0]   <= pwdata_in;
        `SVM_REG_CTL_HI: ctl_q[63:32]  <= pwdata_in;
        `SVM_REG_SPACE:  space_q       <= pwdata_in;
        default: ;
      endcase
    end
  end

  // Control register write is a single pulse, only when idle
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctl_we_q <= 1'b0;
    end else begin
      ctl_we_q <= cmd_wr && pwdata_in[`SVM_CMD_CTL_WR] && (state_q == SVM_IDLE);
    end
  end

  // Sequencer; commands while busy are dropped, access wins over fence
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= SVM_IDLE;
    end else begin
      case (state_q)
        SVM_IDLE: begin
          if (cmd_wr && pwdata_in[`SVM_CMD_ACCESS]) begin
            state_q <= SVM_ACC_REQ;
          end else if (cmd_wr && pwdata_in[`SVM_CMD_FENCE]) begin
            state_q <= SVM_FEN_REQ;
          end
        end
        SVM_ACC_REQ:  if (link.req_ready)   state_q <= SVM_ACC_WAIT;
        SVM_ACC_WAIT: if (link.resp_valid)  state_q <= SVM_IDLE;
        SVM_FEN_REQ:  if (link.fence_ready) state_q <= SVM_FEN_WAIT;
        SVM_FEN_WAIT: if (link.fence_done)  state_q <= SVM_IDLE;
        default:      state_q <= SVM_IDLE;
      endcase
    end
  end

  // Results; completion sets done, a new command clears it, set wins
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      cause_q <= SVM_FETCH;
      hit_q   <= 1'b0;
      pa_q    <= 64'h0000_0000_0000_0000;
    end else if ((state_q == SVM_ACC_WAIT) && link.resp_valid) begin
      done_q  <= 1'b1;
      fault_q <= link.resp_fault;
      cause_q <= link.resp_cause;
      hit_q   <= link.resp_hit;
      pa_q    <= link.resp_paddr;
    end else if ((state_q == SVM_FEN_WAIT) && link.fence_done) begin
      done_q  <= 1'b1;
      fault_q <= 1'b0;
    end else if (cmd_wr && (state_q == SVM_IDLE)) begin
      done_q  <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    prdata_out = 32'h0000_0000;
    case (paddr_in)
      `SVM_REG_ACC:    prdata_out = acc_q;
      `SVM_REG_VA_LO:  prdata_out = va_q[31:0];
      `SVM_REG_VA_HI:  prdata_out = va_q[63:32];
      `SVM_REG_PTE_LO: prdata_out = pte_q[31:0];
      `SVM_REG_PTE_HI: prdata_out = pte_q[63:32];
      `SVM_REG_CTL_LO: prdata_out = link.ctl_rdata[31:0];
      `SVM_REG_CTL_HI: prdata_out = link.ctl_rdata[63:32];
      `SVM_REG_SPACE:  prdata_out = space_q;
      `SVM_REG_STATUS: prdata_out = {26'h000_0000, hit_q, cause_q, fault_q, done_q,
                                     (state_q != SVM_IDLE)};
      `SVM_REG_PA_LO:  prdata_out = pa_q[31:0];
      `SVM_REG_PA_HI:  prdata_out = pa_q[63:32];
      default:         prdata_out = 32'h0000_0000;
    endcase
  end

  // Link drive; operands stay stable through each handshake
  assign link.req_valid      = (state_q == SVM_ACC_REQ);
  assign link.req_kind       = svm_kind_t'(acc_q[1:0]);
  assign link.req_user       = acc_q[`SVM_ACC_USER];
  assign link.req_sum        = acc_q[`SVM_ACC_SUM];
  assign link.req_vaddr      = va_q;
  assign link.req_pte        = pte_q;
  assign link.fence_valid    = (state_q == SVM_FEN_REQ);
  assign link.fence_addr_nz  = acc_q[`SVM_ACC_ADDR_NZ];
  assign link.fence_space_nz = acc_q[`SVM_ACC_SPACE_NZ];
  assign link.fence_addr     = va_q;
  assign link.fence_space    = {32'h0000_0000, space_q};
  assign link.ctl_we         = ctl_we_q;
  assign link.ctl_wdata      = ctl_q;
endmodule : svm_core_end

// [dv/svm_checker.sv]
`timescale 1ns/1ns
module svm_checker (
  input wire logic               clk_sys_in,
  input wire logic               reset_in,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire svm_pkg::svm_kind_t req_kind,
  input wire logic               req_user,
  input wire logic               req_sum,
  input wire logic [63:0]        req_vaddr,
  input wire logic [63:0]        req_pte,
  input wire logic               resp_valid,
  input wire logic               resp_fault,
  input wire svm_pkg::svm_kind_t resp_cause,
  input wire logic               resp_hit,
  input wire logic [63:0]        resp_paddr,
  input wire logic               fence_valid,
  input wire logic               fence_ready,
  input wire logic               fence_done,
  input wire logic               ctl_we,
  input wire logic [63:0]        ctl_wdata,
  input wire logic [63:0]        ctl_rdata
);
  import svm_pkg::*;
  // Taken request and its entry flags; pg means taken while paged
  logic       take;
  logic       pg;
  logic [7:0] fl;
  assign take = req_valid && req_ready;
  assign pg   = take && ctl_rdata[63:60] == 4'h8;
  assign fl   = req_pte[7:0];

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // A hit uses the cached entry, so a bad supplied entry only faults on a miss
  resp_cause_a: assert property (take |=> resp_valid && resp_cause == $past(req_kind))
    else $error("response late or cause wrong");
  inval_entry_a: assert property (pg && !fl[0] |=> resp_fault || resp_hit)
    else $error("invalid entry used");
  ptr_entry_a: assert property (pg && fl[3:1] == 3'b000 |=> resp_fault || resp_hit)
    else $error("pointer entry used as leaf");
  wr_only_a: assert property (pg && fl[2] && !fl[1] |=> resp_fault || resp_hit)
    else $error("write-only entry used");
  sup_fetch_a: assert property (pg && req_kind == SVM_FETCH && !req_user && fl[4]
    |=> resp_fault || resp_hit) else $error("supervisor fetched user page");
  acc_dirty_a: assert property (pg && (!fl[6] || (req_kind == SVM_STORE && !fl[7]))
    |=> resp_fault || resp_hit) else $error("clear accessed or dirty flag passed");
  bare_pass_a: assert property (take && ctl_rdata[63:60] == 4'h0
    |=> !resp_fault && !resp_hit && resp_paddr == $past(req_vaddr)) else $error("bare mode wrong");
  fence_done_a: assert property (fence_valid && fence_ready |=> fence_done)
    else $error("fence not completed");
  mode_keep_a: assert property (ctl_we && ctl_wdata[63:60] inside {[4'h1:4'h7],
    [4'h9:4'hF]} |=> $stable(ctl_rdata)) else $error("unsupported mode accepted");
endmodule : svm_checker

// [dv/three_level_39bit_paging_mmu_permission_and_fence_tb.sv]
`timescale 1ns/1ns
`include "svm_params.svh"
module three_level_39bit_paging_mmu_permission_and_fence_tb;
  import svm_pkg::*;
  typedef struct packed {
    logic        an;
    logic        sn;
    logic        ub;
    logic        ka;
    logic        kb;
    logic [31:0] sp;
  } svm_frow_t;
  localparam logic [63:0] VA_A = 64'h0000_0000_0040_1000;
  localparam logic [63:0] VA_B = 64'h0000_0000_0080_2000;
  localparam logic [63:0] PT_A = 64'h0000_0000_0055_54C3;
  localparam logic [63:0] PT_B = 64'h0000_0000_0066_64E3;
  localparam logic [63:0] CTL  = 64'h8000_5000_0000_0123;
  logic        clk_sys_in;
  logic        reset_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] tlb_v;
  logic [63:0] ctl_o;
  logic [32:0] exp_q[$];
  int          bad_count;
  int          n_checks;
  svm_frow_t   rows[5];
  svm_if       link ();

  svm_mmu_dev #(.TLB_ENTRIES(16), .TAG_W(16)) svm_mmu_dev_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .link(link), .ctl_out(ctl_o),
    .tlb_valid_out(tlb_v));
  svm_core_end svm_core_end_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link(link));
  svm_checker svm_checker_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_kind(link.req_kind), .req_user(link.req_user),
    .req_sum(link.req_sum), .req_vaddr(link.req_vaddr), .req_pte(link.req_pte),
    .resp_valid(link.resp_valid), .resp_fault(link.resp_fault),
    .resp_cause(link.resp_cause), .resp_hit(link.resp_hit), .resp_paddr(link.resp_paddr),
    .fence_valid(link.fence_valid), .fence_ready(link.fence_ready),
    .fence_done(link.fence_done), .ctl_we(link.ctl_we), .ctl_wdata(link.ctl_wdata),
    .ctl_rdata(link.ctl_rdata));

  // Free-running core clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Read results are matched against notes in issue order
  always @(posedge clk_sys_in) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check({31'h0, pslverr, prdata}, {31'h0, exp_q.pop_front()});
    end
  end

  // Expected fault for a fresh paged miss: m is {space,addr,sum,user,kind}
  function automatic logic flt(input logic [7:0] p, input logic [5:0] m);
    return !p[0] || (p[2] && !p[1]) || p[3:1] == 3'b000
      || (m[1:0] == 2'd0 && !p[3]) || (m[1:0] == 2'd1 && !p[1])
      || (m[1:0] == 2'd2 && !p[2]) || (m[2] && !p[4])
      || (!m[2] && p[4] && (m[1:0] == 2'd0 || !m[3]))
      || !p[6] || (m[1:0] == 2'd2 && !p[7]);
  endfunction : flt

  function automatic logic [63:0] pa_of(input logic [63:0] va, input logic [63:0] pt);
    return {8'h00, pt[53:10], va[11:0]};
  endfunction : pa_of

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1) begin
      if (n == 20) begin
        bad_count++;
        complete_run();
      end
      n++;
      @(posedge clk_sys_in);
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
  endtask : wr64

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000, r);
  endtask : rd

  // Issue a command and poll the done flag under a bound
  task automatic run(input logic [31:0] cmd);
    logic [31:0] r;
    int n;
    wr(`SVM_REG_CMD, cmd);
    n = 0;
    r = 32'h0000_0000;
    while (r[1] !== 1'b1) begin
      if (n == 20) begin
        bad_count++;
        complete_run();
      end
      apb(1'b0, `SVM_REG_STATUS, 32'h0000_0000, r);
      n++;
    end
  endtask : run

  task automatic acc(input logic [63:0] va, input logic [63:0] pt, input logic [5:0] m,
                     input logic f, input logic h, input logic [63:0] pa);
    wr64(`SVM_REG_VA_LO, va);
    wr64(`SVM_REG_PTE_LO, pt);
    wr(`SVM_REG_ACC, {26'h000_0000, m});
    run(32'h0000_0001);
    rd(`SVM_REG_STATUS, {27'h000_0000, h, m[1:0], f, 2'b10});
    if (!f) begin
      rd(`SVM_REG_PA_LO, {1'b0, pa[31:0]});
      rd(`SVM_REG_PA_HI, {1'b0, pa[63:32]});
    end
  endtask : acc

  // Main sequence
  initial begin
    logic [63:0] va;
    logic [63:0] pt;
    logic [5:0]  m;
    logic        ia;
    logic        ib;
    bad_count = 0;
    n_checks = 0;
    reset_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rows[0] = {5'b00000, 32'h0000_0000};
    rows[1] = {5'b01001, 32'h0000_0005};
    rows[2] = {5'b10110, 32'h0000_0000};
    rows[3] = {5'b11001, 32'hFFFF_0005};
    rows[4] = {5'b11011, 32'h0000_0006};
    void'($urandom(50));
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    rd(`SVM_REG_CTL_HI, 33'h0_0000_0000);
    rd(`SVM_REG_STATUS, 33'h0_0000_0000);
    rd(8'h30, 33'h1_0000_0000);
    rd(8'h02, 33'h1_0000_0000);
    acc(VA_A, 64'h0000_0000_0000_0000, 6'h01, 1'b0, 1'b0, VA_A);
    wr64(`SVM_REG_CTL_LO, 64'h9000_5000_0000_0123);
    wr(`SVM_REG_CMD, 32'h0000_0004);
    rd(`SVM_REG_CTL_HI, 33'h0_0000_0000);
    wr64(`SVM_REG_CTL_LO, CTL);
    wr(`SVM_REG_CMD, 32'h0000_0004);
    rd(`SVM_REG_CTL_LO, {1'b0, CTL[31:0]});
    rd(`SVM_REG_CTL_HI, {1'b0, CTL[63:32]});
    check(ctl_o, CTL);
    // Fill a private and a global page, fence, then let the refills show what survived
    ia = 1'b0;
    ib = 1'b0;
    for (int i = 0; i < 5; i++) begin
      acc(VA_A, PT_A, 6'h01, 1'b0, ia, pa_of(VA_A, PT_A));
      acc(VA_B, PT_B, 6'h01, 1'b0, ib, pa_of(VA_B, PT_B));
      wr64(`SVM_REG_VA_LO, rows[i].ub ? VA_B : VA_A);
      wr(`SVM_REG_SPACE, rows[i].sp);
      wr(`SVM_REG_ACC, {26'h000_0000, rows[i].sn, rows[i].an, 4'h0});
      run(32'h0000_0002);
      ia = rows[i].ka;
      ib = rows[i].kb;
      check($countones(tlb_v), ia + ib);
    end
    wr(`SVM_REG_CMD, 32'h0000_0004);
    acc(VA_A, PT_A, 6'h01, 1'b0, ia, pa_of(VA_A, PT_A));
    acc(VA_B, PT_B, 6'h01, 1'b0, ib, pa_of(VA_B, PT_B));
    // Random canonical addresses and entries; odd passes bias towards legal pages
    for (int i = 0; i < 48; i++) begin
      va = {$urandom, $urandom};
      va[63:39] = {25{va[38]}};
      pt = {$urandom, $urandom};
      if (i % 2 == 1) pt[7:0] = pt[7:0] | 8'hC1;
      if (pt[3:1] == 3'b000) pt[7:4] = pt[7:4] & 4'h2;
      m = {2'b00, 2'($urandom), 2'($urandom % 3)};
      acc(va, pt, m, flt(pt[7:0], m), 1'b0, pa_of(va, pt));
    end
    complete_run();
  end
endmodule : three_level_39bit_paging_mmu_permission_and_fence_tb
